// ### sim/slfc_cache_model.sv
// Data cache model that takes store-buffer writes, promptly or slowly
`default_nettype none
module slfc_cache_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic wr_valid,
    output logic wr_ready,
    output int n_writes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial wr_ready = 1'b0;
    // Slow mode refuses every other cycle so the head entry must hold its write
    always @(posedge clk)
        wr_ready <= slow ? ~wr_ready : 1'b1;
    always @(posedge clk)
        if (rst)
            n_writes <= 0;
        else if (wr_valid && wr_ready)
            n_writes <= n_writes + 1;
endmodule
`default_nettype wire

// ### sim/slfc_testbench.sv
// Self-checking bench for the store-to-load forward check
`default_nettype none
`define CHK(nm, exp, got) \
    begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [slfc_pkg::ADDR_W-1:0] slfc_addr_t;
    typedef logic [slfc_pkg::DATA_W-1:0] slfc_data_t;
    localparam int FWD = 0;
    localparam int STL = 1;
    localparam int CAC = 2;
    logic clk, rst, st_valid, st_high, retire, ld_valid, slow;
    logic stall, to_cache, fwd_valid, dc_valid, dc_ready, st_ready;
    slfc_addr_t st_addr, ld_addr, dc_addr;
    logic [1:0] st_size, ld_size, dc_size;
    slfc_data_t st_data, ld_data, dc_data;
    int n_writes;
    int errors = 0;
    int n_compared = 0;
    // Stores owed to the cache, oldest first
    slfc_addr_t exp_addr[$];
    logic [1:0] exp_size[$];
    slfc_data_t exp_data[$];

    slfc_top #(.DEPTH(8)) dut_u (.CLOCK(clk), .RST(rst), .ST_VALID(st_valid), .ST_READY(st_ready),
        .ST_ADDR(st_addr), .ST_SIZE(st_size), .ST_DATA(st_data), .ST_HIGH_BYTE(st_high),
        .ROB_RETIRE(retire), .LD_VALID(ld_valid), .LD_ADDR(ld_addr), .LD_SIZE(ld_size),
        .LD_STALL(stall), .LD_TO_CACHE(to_cache), .LD_FWD_VALID(fwd_valid),
        .LD_DATA(ld_data), .DC_WR_VALID(dc_valid), .DC_WR_READY(dc_ready),
        .DC_WR_ADDR(dc_addr), .DC_WR_SIZE(dc_size), .DC_WR_DATA(dc_data));
    slfc_cache_model dc_u (.clk(clk), .rst(rst), .slow(slow), .wr_valid(dc_valid),
        .wr_ready(dc_ready), .n_writes(n_writes));

    // Valid and ready stand from one rising edge to the next, so the write taken there is seen here
    always @(negedge clk)
    begin
        if (!rst && dc_valid && dc_ready)
        begin
            `CHK("dc_pending", 1'b1, exp_addr.size() > 0)
            if (exp_addr.size() > 0)
            begin
                `CHK("dc_addr", exp_addr[0], dc_addr)
                `CHK("dc_size", exp_size[0], dc_size)
                `CHK("dc_data", exp_data[0], dc_data)
                void'(exp_addr.pop_front());
                void'(exp_size.pop_front());
                void'(exp_data.pop_front());
            end
        end
    end

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic push(input slfc_addr_t a, input logic [1:0] s, input slfc_data_t d,
        input logic h);
        @(negedge clk);
        `CHK("st_ready", 1'b1, st_ready)
        {st_valid, st_addr, st_size, st_data, st_high} = {1'b1, a, s, d, h};
        exp_addr.push_back(a);
        exp_size.push_back(s);
        exp_data.push_back(d & ((s == slfc_pkg::SZ_QWORD) ? '1 : ((64'h1 << (8 << s)) - 64'h1)));
        @(negedge clk);
        st_valid = 1'b0;
    endtask

    // Load held for one edge; the answer is judged in cycle 0 and cycle 1
    task automatic load(input slfc_addr_t a, input logic [1:0] s, input int k,
        input slfc_data_t d);
        @(negedge clk);
        {ld_valid, ld_addr, ld_size} = {1'b1, a, s};
        #1;
        `CHK("stall", k == STL, stall)
        `CHK("to_cache", k == CAC, to_cache)
        @(negedge clk);
        ld_valid = 1'b0;
        `CHK("fwd_valid", k == FWD, fwd_valid)
        if (k == FWD)
            `CHK("ld_data", d, ld_data)
    endtask

    // Holds a stalled load while the buffer retires and drains n entries
    task automatic drain(input slfc_addr_t a, input logic [1:0] s, input int n);
        int w0;
        w0 = n_writes;
        @(negedge clk);
        {ld_valid, ld_addr, ld_size} = {1'b1, a, s};
        repeat (3)
        begin
            @(negedge clk);
            `CHK("dc_valid", 1'b0, dc_valid)
            `CHK("stall_hold", 1'b1, stall)
        end
        retire = 1'b1;
        repeat (n) @(negedge clk);
        retire = 1'b0;
        for (int i = 0; i < 100 && (stall || dc_valid); i++)
            @(negedge clk);
        if (stall !== 1'b0 || dc_valid !== 1'b0)
        begin
            errors++;
            give_verdict();
        end
        `CHK("to_cache_after", 1'b1, to_cache)
        `CHK("writes", w0 + n, n_writes)
        ld_valid = 1'b0;
    endtask

    task automatic t_exact();
        push(48'h100, slfc_pkg::SZ_DWORD, 64'h11223344, 1'b0);
        load(48'h100, slfc_pkg::SZ_DWORD, FWD, 64'h11223344);
        load(48'h100, slfc_pkg::SZ_WORD, FWD, 64'h3344);
        load(48'h102, slfc_pkg::SZ_WORD, STL, 0);
        load(48'h100, slfc_pkg::SZ_QWORD, STL, 0);
        drain(48'h100, slfc_pkg::SZ_QWORD, 1);
    endtask

    task automatic t_qword();
        push(48'h200, slfc_pkg::SZ_QWORD, 64'h8877665544332211, 1'b0);
        load(48'h200, slfc_pkg::SZ_DWORD, FWD, 64'h44332211);
        load(48'h204, slfc_pkg::SZ_DWORD, STL, 0);
        drain(48'h204, slfc_pkg::SZ_DWORD, 1);
    endtask

    task automatic t_misalign();
        push(48'h304, slfc_pkg::SZ_QWORD, 64'h5A5A, 1'b0);
        load(48'h304, slfc_pkg::SZ_QWORD, STL, 0);
        push(48'h321, slfc_pkg::SZ_WORD, 64'h1234, 1'b0);
        load(48'h321, slfc_pkg::SZ_BYTE, STL, 0);
        drain(48'h321, slfc_pkg::SZ_BYTE, 2);
    endtask

    task automatic t_high();
        push(48'h400, slfc_pkg::SZ_BYTE, 64'hCD, 1'b0);
        load(48'h400, slfc_pkg::SZ_BYTE, FWD, 64'hCD);
        push(48'h400, slfc_pkg::SZ_BYTE, 64'hAB, 1'b1);
        load(48'h400, slfc_pkg::SZ_BYTE, STL, 0);
        drain(48'h400, slfc_pkg::SZ_BYTE, 2);
    endtask

    task automatic t_young();
        slow = 1'b1;
        push(48'h500, slfc_pkg::SZ_DWORD, 64'hAAAA0001, 1'b0);
        push(48'h500, slfc_pkg::SZ_DWORD, 64'hBBBB0002, 1'b0);
        load(48'h500, slfc_pkg::SZ_DWORD, FWD, 64'hBBBB0002);
        push(48'h502, slfc_pkg::SZ_WORD, 64'h7777, 1'b0);
        load(48'h500, slfc_pkg::SZ_DWORD, STL, 0);
        drain(48'h500, slfc_pkg::SZ_DWORD, 3);
        slow = 1'b0;
    endtask

    task automatic t_false();
        push(48'h600, slfc_pkg::SZ_WORD, 64'h4242, 1'b0);
        load(48'h602, slfc_pkg::SZ_WORD, STL, 0);
        load(48'h604, slfc_pkg::SZ_WORD, CAC, 0);
        push(48'h1620, slfc_pkg::SZ_DWORD, 64'h9999, 1'b0);
        load(48'h620, slfc_pkg::SZ_DWORD, STL, 0);
        drain(48'h620, slfc_pkg::SZ_DWORD, 2);
    endtask

    task automatic do_reset(input int n);
        rst = 1'b1;
        exp_addr.delete();
        exp_size.delete();
        exp_data.delete();
        // Counting rising edges avoids the start-up transition of the clock counting as one
        repeat (n) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {st_valid, st_addr, st_size, st_data, st_high} = '0;
        {retire, ld_valid, ld_addr, ld_size, slow} = '0;
        do_reset(12);
        t_exact();
        t_qword();
        t_misalign();
        t_high();
        do_reset(2);
        t_young();
        t_false();
        give_verdict();
    end
endmodule
`default_nettype wire

// ### verilog/slfc_cmp_if.sv
// Link between the buffer search and one entry comparator
`default_nettype none
interface slfc_cmp_if;
    logic clk;
    logic rst;
    logic [slfc_pkg::ADDR_W-1:0] ld_addr;
    logic [slfc_pkg::SIZE_W-1:0] ld_size;
    logic st_valid;
    logic [slfc_pkg::ADDR_W-1:0] st_addr;
    logic [slfc_pkg::SIZE_W-1:0] st_size;
    logic st_high;
    logic hit;
    logic ok;
    modport chk (input clk, rst, ld_addr, ld_size, st_valid, st_addr, st_size, st_high,
        output hit, ok);
    modport src (output clk, rst, ld_addr, ld_size, st_valid, st_addr, st_size, st_high,
        input hit, ok);
endinterface
`default_nettype wire

// ### verilog/slfc_entry_check.sv
// Compares one store-buffer entry against the pending load
`default_nettype none
module slfc_entry_check
(
    slfc_cmp_if.chk c
);
    function automatic logic misaligned(input logic [slfc_pkg::ADDR_W-1:0] a,
        input logic [slfc_pkg::SIZE_W-1:0] sz);
        logic [slfc_pkg::ALIGN_BITS-1:0] m;
        begin
            m = 3'h0;
            case (sz)
                slfc_pkg::SZ_WORD: m = 3'h1;
                slfc_pkg::SZ_DWORD: m = 3'h3;
                slfc_pkg::SZ_QWORD: m = 3'h7;
                default: m = 3'h0;
            endcase
            misaligned = (a[slfc_pkg::ALIGN_BITS-1:0] & m) != 3'h0; // RULE7
        end
    endfunction

    // One past the last byte; the extra bit keeps the top of the address space from wrapping
    function automatic logic [slfc_pkg::ADDR_W:0] end_addr(
        input logic [slfc_pkg::ADDR_W-1:0] a,
        input logic [slfc_pkg::SIZE_W-1:0] sz);
        begin
            end_addr = {1'b0, a} + ((slfc_pkg::ADDR_W + 1)'(1) << sz);
        end
    endfunction

    logic same_window;
    logic same_start;
    logic width_ok;
    logic align_ok;
    logic overlap;

    always_comb
    begin
        // Only bits 11..2 are compared, so same-dword or 4K aliases match falsely
        same_window = c.ld_addr[slfc_pkg::MATCH_HI:slfc_pkg::MATCH_LO]
            == c.st_addr[slfc_pkg::MATCH_HI:slfc_pkg::MATCH_LO]; // RULE12
        same_start = c.ld_addr == c.st_addr; // RULE1 RULE6
        width_ok = c.ld_size <= c.st_size; // RULE2 RULE5 RULE8
        align_ok = !misaligned(c.ld_addr, c.ld_size) && !misaligned(c.st_addr, c.st_size); // RULE3
        // A true overlap outside the window must still block, or the load reads stale cache data
        overlap = ({1'b0, c.ld_addr} < end_addr(c.st_addr, c.st_size))
            && ({1'b0, c.st_addr} < end_addr(c.ld_addr, c.ld_size)); // RULE5 RULE6
        c.hit = c.st_valid && (same_window || overlap);
        c.ok = c.hit && same_start && width_ok && align_ok && !c.st_high; // RULE4
    end

    AST_OK_START: assert property (@(posedge c.clk) disable iff (c.rst) // RULE1
        c.ok |-> (c.ld_addr == c.st_addr && c.hit))
        else $error("forward allowed with different start addresses");
    AST_OK_WIDTH: assert property (@(posedge c.clk) disable iff (c.rst) // RULE2
        (c.hit && c.ld_size > c.st_size) |-> !c.ok)
        else $error("forward allowed from narrower store");
    AST_OK_ALIGN: assert property (@(posedge c.clk) disable iff (c.rst) // RULE3
        (c.hit && c.st_size == slfc_pkg::SZ_QWORD && c.st_addr[2:0] != 3'h0) |-> !c.ok)
        else $error("forward allowed from misaligned quadword store");
    AST_OK_HIGH: assert property (@(posedge c.clk) disable iff (c.rst) // RULE4
        c.st_high |-> !c.ok)
        else $error("forward allowed from high-byte store");
    AST_HIT_WINDOW: assert property (@(posedge c.clk) disable iff (c.rst) // RULE12
        (c.st_valid && c.ld_addr[11:2] == c.st_addr[11:2]) |-> c.hit)
        else $error("dependency missed on matching address window");
endmodule
`default_nettype wire

// ### verilog/slfc_pkg.sv
// Shared constants for the store-to-load forward check
`default_nettype none
package slfc_pkg;
    localparam int ADDR_W = 48;
    localparam int DATA_W = 64;
    localparam int SIZE_W = 2;
    // Operand size as log2 of the byte count
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h2;
    localparam logic [1:0] SZ_QWORD = 2'h3;
    // Dependency compare window
    localparam int MATCH_LO = 2;
    localparam int MATCH_HI = 11;
    localparam int ALIGN_BITS = 3;
    localparam int DWORD_BITS = 32;
endpackage
`default_nettype wire

// ### verilog/slfc_top.sv
// Store buffer with store-to-load forward eligibility and load stall
// How it works
// [RULE1] A load forwards only from a store with exactly the same start byte address.
// [RULE2] A load forwards only when it is no wider than the store feeding it.
// [RULE3] A misaligned load or misaligned store is never forwarded.
// [RULE4] A store whose data came from a high-byte register is never forwarded.
// [RULE5] A narrower store overlapping part of the load refuses forwarding and stalls the load.
// [RULE6] A wider store with a different start address refuses forwarding and stalls the load.
// [RULE7] An access is misaligned when its address is not a multiple of its size.
// [RULE8] The low 32 bits of an aligned quadword store feed a doubleword load at its start.
// [RULE9] A forwarded load gets its data straight from the matching buffer entry.
// [RULE10] A refused load is stalled until the blocking store has drained to the cache.
// [RULE11] An entry writes the cache only after the reorder buffer has retired it.
// [RULE12] Dependency is found by comparing address bits 11 to 2, allowing false matches.
// [RULE13] The youngest matching store alone decides whether forwarding is allowed.
`default_nettype none
module slfc_top
#(
    parameter int DEPTH = 8
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic ST_VALID,
    output logic ST_READY,
    input wire logic [slfc_pkg::ADDR_W-1:0] ST_ADDR,
    input wire logic [slfc_pkg::SIZE_W-1:0] ST_SIZE,
    input wire logic [slfc_pkg::DATA_W-1:0] ST_DATA,
    input wire logic ST_HIGH_BYTE,
    input wire logic ROB_RETIRE,
    input wire logic LD_VALID,
    input wire logic [slfc_pkg::ADDR_W-1:0] LD_ADDR,
    input wire logic [slfc_pkg::SIZE_W-1:0] LD_SIZE,
    output logic LD_STALL,
    output logic LD_TO_CACHE,
    output logic LD_FWD_VALID,
    output logic [slfc_pkg::DATA_W-1:0] LD_DATA,
    output logic DC_WR_VALID,
    input wire logic DC_WR_READY,
    output logic [slfc_pkg::ADDR_W-1:0] DC_WR_ADDR,
    output logic [slfc_pkg::SIZE_W-1:0] DC_WR_SIZE,
    output logic [slfc_pkg::DATA_W-1:0] DC_WR_DATA
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_ONE = 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE = 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        begin
            ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
        end
    endfunction

    function automatic logic [slfc_pkg::DATA_W-1:0] size_mask(
        input logic [slfc_pkg::SIZE_W-1:0] sz);
        begin
            case (sz)
                slfc_pkg::SZ_BYTE: size_mask = 64'h0000_0000_0000_00FF;
                slfc_pkg::SZ_WORD: size_mask = 64'h0000_0000_0000_FFFF;
                slfc_pkg::SZ_DWORD: size_mask = 64'h0000_0000_FFFF_FFFF;
                default: size_mask = 64'hFFFF_FFFF_FFFF_FFFF;
            endcase
        end
    endfunction

    logic [slfc_pkg::ADDR_W-1:0] ent_addr_reg [DEPTH];
    logic [slfc_pkg::ADDR_W-1:0] ent_addr_next [DEPTH];
    logic [slfc_pkg::SIZE_W-1:0] ent_size_reg [DEPTH];
    logic [slfc_pkg::SIZE_W-1:0] ent_size_next [DEPTH];
    logic [slfc_pkg::DATA_W-1:0] ent_data_reg [DEPTH];
    logic [slfc_pkg::DATA_W-1:0] ent_data_next [DEPTH];
    logic [DEPTH-1:0] ent_high_reg;
    logic [DEPTH-1:0] ent_high_next;
    logic [PTR_W-1:0] head_reg;
    logic [PTR_W-1:0] head_next;
    logic [PTR_W-1:0] tail_reg;
    logic [PTR_W-1:0] tail_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] cmt_reg;
    logic [CNT_W-1:0] cmt_next;
    logic fwd_valid_reg;
    logic fwd_valid_next;
    logic [slfc_pkg::DATA_W-1:0] ld_data_reg;
    logic [slfc_pkg::DATA_W-1:0] ld_data_next;

    logic [DEPTH-1:0] ent_live;
    logic [DEPTH-1:0] ent_hit;
    logic [DEPTH-1:0] ent_ok;
    logic found;
    logic found_ok;
    logic [PTR_W-1:0] found_idx;
    logic push;
    logic drain;
    logic retire;

    // Which slots currently hold a store
    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            ent_live[i] = (PTR_W'(i) - head_reg) < PTR_W'(count_reg)
                || count_reg == CNT_FULL;
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_cmp
            slfc_cmp_if cif();
            assign cif.clk = CLOCK;
            assign cif.rst = RST;
            assign cif.ld_addr = LD_ADDR;
            assign cif.ld_size = LD_SIZE;
            assign cif.st_valid = ent_live[g];
            assign cif.st_addr = ent_addr_reg[g];
            assign cif.st_size = ent_size_reg[g];
            assign cif.st_high = ent_high_reg[g];
            assign ent_hit[g] = cif.hit;
            assign ent_ok[g] = cif.ok;
            slfc_entry_check u_chk
            (
                .c(cif)
            );
        end
    endgenerate

    // Youngest first; older matches are shadowed by the first one found
    always_comb
    begin
        logic [PTR_W-1:0] idx;
        idx = '0;
        found = 1'b0;
        found_idx = '0;
        for (int k = 0; k < DEPTH; k++)
        begin
            idx = tail_reg - PTR_ONE - PTR_W'(k);
            if (!found && ent_hit[idx])
            begin
                found = 1'b1; // RULE13
                found_idx = idx;
            end
        end
        found_ok = found && ent_ok[found_idx];
    end

    // A refused load is re-evaluated each cycle; it clears once the entry drains
    assign LD_STALL = LD_VALID && found && !found_ok; // RULE5 RULE6 RULE10
    assign LD_TO_CACHE = LD_VALID && !found;
    assign ST_READY = count_reg != CNT_FULL;
    assign DC_WR_VALID = cmt_reg != '0; // RULE11
    assign DC_WR_ADDR = ent_addr_reg[head_reg];
    assign DC_WR_SIZE = ent_size_reg[head_reg];
    assign DC_WR_DATA = ent_data_reg[head_reg];
    assign LD_FWD_VALID = fwd_valid_reg;
    assign LD_DATA = ld_data_reg;

    always_comb
    begin
        push = ST_VALID && ST_READY;
        drain = DC_WR_VALID && DC_WR_READY;
        // Retire notices beyond the buffered stores are ignored
        retire = ROB_RETIRE && (cmt_reg != count_reg);
        ent_addr_next = ent_addr_reg;
        ent_size_next = ent_size_reg;
        ent_data_next = ent_data_reg;
        ent_high_next = ent_high_reg;
        head_next = head_reg;
        tail_next = tail_reg;
        count_next = count_reg;
        cmt_next = cmt_reg;
        if (push)
        begin
            ent_addr_next[tail_reg] = ST_ADDR;
            ent_size_next[tail_reg] = ST_SIZE;
            ent_data_next[tail_reg] = ST_DATA & size_mask(ST_SIZE);
            ent_high_next[tail_reg] = ST_HIGH_BYTE;
            tail_next = ptr_inc(tail_reg);
        end
        if (drain)
        begin
            head_next = ptr_inc(head_reg); // RULE10
        end
        count_next = count_reg + (push ? CNT_ONE : '0) - (drain ? CNT_ONE : '0);
        cmt_next = cmt_reg + (retire ? CNT_ONE : '0) - (drain ? CNT_ONE : '0); // RULE11
        fwd_valid_next = LD_VALID && found_ok;
        ld_data_next = ld_data_reg;
        if (LD_VALID && found_ok)
        begin
            // Same start address, so the low bytes of the entry are the load's bytes
            ld_data_next = ent_data_reg[found_idx] & size_mask(LD_SIZE); // RULE8 RULE9
        end
    end

    always_ff @(posedge CLOCK)
    begin
        ent_addr_reg <= ent_addr_next;
        ent_size_reg <= ent_size_next;
        ent_data_reg <= ent_data_next;
        if (RST)
        begin
            ent_high_reg <= '0;
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= '0;
            cmt_reg <= '0;
            fwd_valid_reg <= 1'b0;
            ld_data_reg <= '0;
        end
        else
        begin
            ent_high_reg <= ent_high_next;
            head_reg <= head_next;
            tail_reg <= tail_next;
            count_reg <= count_next;
            cmt_reg <= cmt_next;
            fwd_valid_reg <= fwd_valid_next;
            ld_data_reg <= ld_data_next;
        end
    end

    AST_STALL_NO_FWD: assert property (@(posedge CLOCK) disable iff (RST) // RULE10
        LD_STALL |=> !LD_FWD_VALID)
        else $error("stalled load was forwarded");
    AST_FWD_NEXT: assert property (@(posedge CLOCK) disable iff (RST) // RULE9
        (LD_VALID && found_ok) |=> (LD_FWD_VALID
            && LD_DATA == ($past(ent_data_reg[found_idx]) & size_mask($past(LD_SIZE)))))
        else $error("forward data not delivered from entry");
    AST_DRAIN_RETIRED: assert property (@(posedge CLOCK) disable iff (RST) // RULE11
        DC_WR_VALID |-> (cmt_reg > '0 && cmt_reg <= count_reg))
        else $error("cache write of unretired store");
    AST_DW_UPPER_ZERO: assert property (@(posedge CLOCK) disable iff (RST) // RULE8
        (LD_VALID && found_ok && LD_SIZE == slfc_pkg::SZ_DWORD)
            |=> LD_DATA[63:32] == 32'h0000_0000)
        else $error("doubleword forward carries upper half");
    AST_STALL_CLEARS: assert property (@(posedge CLOCK) disable iff (RST) // RULE10
        (LD_STALL && count_reg == CNT_ONE && drain && !push
            && $stable(LD_ADDR) && LD_VALID) |=> (LD_VALID && $stable(LD_ADDR)) |-> !LD_STALL)
        else $error("stall outlived its only blocking store");
    AST_NARROW_STALL: assert property (@(posedge CLOCK) disable iff (RST) // RULE5
        (LD_VALID && found && ent_size_reg[found_idx] < LD_SIZE) |-> LD_STALL)
        else $error("narrow store did not stall wider load");
endmodule
`default_nettype wire
